// ### rtl/rcfr_pkg.sv
// Constants of the rail 2 register bank
package rcfr_pkg;
   // Command codes of the registers on the second page
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] OFS_DROOP_CTRL3 = 8'h19;
   localparam logic [7:0] OFS_ADDR_TELEM = 8'h1A;
   localparam logic [7:0] OFS_REPORT_GAIN = 8'h1B;
   localparam logic [7:0] OFS_MON_GAIN = 8'h1C;
   localparam logic [7:0] OFS_MULTI_CFG = 8'h1D;
   localparam logic [7:0] OFS_CFG_OFFSET = 8'h1E;
   localparam logic [7:0] OFS_LAST_FAULTS1 = 8'h20;
   localparam logic [1:0] REG_PAGE = 2'h2;
   // Reset values
   localparam logic [15:0] RST_DROOP_CTRL3 = 16'h0000;
   localparam logic [15:0] RST_ADDR_TELEM = 16'h0000;
   localparam logic [15:0] RST_REPORT_GAIN = 16'h0000;
   localparam logic [15:0] RST_MON_GAIN = 16'h0000;
   localparam logic [15:0] RST_MULTI_CFG = 16'h0000;
   localparam logic [15:0] RST_CFG_OFFSET = 16'h0000;
   // Writable bits; reserved and read-only bits stay zero
   localparam logic [15:0] WMASK_DROOP_CTRL3 = 16'hFFFF;
   localparam logic [15:0] WMASK_ADDR_TELEM = 16'hFFFF;
   localparam logic [15:0] WMASK_REPORT_GAIN = 16'h3FFF;
   localparam logic [15:0] WMASK_MON_GAIN = 16'hFFFF;
   localparam logic [15:0] WMASK_MULTI_CFG = 16'hDFFF;
   localparam logic [15:0] WMASK_CFG_OFFSET = 16'hDFFF;
   // Single-bit field positions
   localparam int BIT_INJ_TYPE = 2;
   localparam int BIT_IIN_SRC = 15;
   localparam int BIT_SPEC_GEN = 7;
   localparam int BIT_HC_SUPPORT = 6;
   localparam int BIT_HC_INIT = 5;
   localparam int BIT_ALERT_SEL = 4;
   localparam int BIT_SYS_MODE = 3;
   localparam int BIT_VOLT_FLT_EN = 2;
   localparam int BIT_VSYS_PIN = 1;
   localparam int BIT_TEMP_PIN = 0;
   localparam int BIT_PIN_RESET_EN = 15;
   localparam int BIT_HALF_TRACK = 14;
   localparam int BIT_VID_STEP = 3;
   localparam int BIT_CS_SUM_LVL = 15;
   localparam int BIT_THR_HALF = 14;
   localparam int BIT_REMOTE_GAIN = 9;
   localparam int BIT_FLT_SELF_R2 = 15;
   localparam int BIT_FLT_SELF_R1 = 14;
   localparam int BIT_FLT_IIN = 13;
   // Monitor digital gain divisor, as a shift
   localparam int MON_DIV_SHIFT = 10;
   localparam int GAIN_EXP_BASE = 10;
   // Pin reset low time in cycles
   localparam int PIN_RESET_TIME_MS = 4;
   localparam int CLK_FREQ_HZ = 50_000_000;
   localparam int PIN_RESET_CYCLES = PIN_RESET_TIME_MS * (CLK_FREQ_HZ / 1000);
endpackage : rcfr_pkg

// ### rtl/rcfr_pin_reset.sv
// Data pin low-time detector for boot reset
`timescale 1ns/100ps
module rcfr_pin_reset #(
   parameter int HOLD_CYCLES = 200000
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic data_pin_in,
   output logic boot_reset
);
   logic sync_a;
   logic sync_b;
   logic [23:0] low_count;
   logic fired;
   wire hold_done = (low_count == 24'(HOLD_CYCLES - 1));

   // Two-stage synchroniser for the pin
   always_ff @(posedge clk) begin
      sync_a <= sys_rst ? 1'b1 : data_pin_in;
      sync_b <= sys_rst ? 1'b1 : sync_a;
   end

   // Count low time; one pulse per low period
   always_ff @(posedge clk) begin
      if (sys_rst || sync_b || !enable) begin
         low_count <= 24'h000000;
         fired <= 1'b0;
         boot_reset <= 1'b0;
      end else begin
         boot_reset <= hold_done && !fired; // [R15]
         if (hold_done) begin
            fired <= 1'b1;
         end else begin
            low_count <= low_count + 24'h000001;
         end
      end
   end
endmodule // rcfr_pin_reset

// ### rtl/rcfr_monitor_calc.sv
// Digital gain stage that turns the monitor sample into the report value
`timescale 1ns/100ps
module rcfr_monitor_calc
   import rcfr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic sample_valid,
   input wire logic [11:0] adc_sample,
   input wire logic [10:0] digital_gain,
   output logic [12:0] monitor_final,
   output logic monitor_valid
);
   wire [22:0] product = 23'(adc_sample) * 23'(digital_gain);
   wire [12:0] scaled = 13'(product >> MON_DIV_SHIFT);

   // Multiply by gain and divide by 1024, registered
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         monitor_final <= 13'h0000;
         monitor_valid <= 1'b0;
      end else begin
         monitor_valid <= sample_valid;
         if (sample_valid) begin
            monitor_final <= scaled; // [R14]
         end
      end
   end
endmodule // rcfr_monitor_calc

// ### rtl/rcfr_regs.sv
// Rail 2 configuration, reporting and last-fault register bank
`timescale 1ns/100ps
// Overview of operation
// R1: Droop resistor code maps 0.25k to 3.5k
// R2: Bit 2 picks AC droop; bandwidth then applies
// R3: Bit 15 picks input-current report source
// R4: Bits 14:12 give upper bus address bits
// R5: Debug bit picks address pin or field
// R6: Bit 7 selects regulator spec generation
// R7: Legacy mode support, initial state, processor toggle
// R8: Alert output choice and system-power mode
// R9: Voltage fault enable and pin mode selects
// R10: Reserved bits ignore writes, read zero
// R11: Report gain mantissa scaled by exponent
// R12: Monitor resistor code selects resistor value
// R13: Mirror gain code gives 2,3,5,8 over 64
// R14: Monitor sample times gain over 1024
// R15: Data pin low 4ms returns boot voltage
// R16: Half tracking makes rail 2 half rail 1
// R17: Boot voltage code and VID step size
// R18: Phase count code decodes to phases
// R19: Sense level and threshold halving select
// R20: Remote amplifier gain unity or half
// R21: Signed report offset with scaled resolution
// R22: Input over-limit flag, latched until clear for the pin fault source; follows the live warning when source select is set
module rcfr_regs
   import rcfr_pkg::*;
#(
   parameter int PIN_RESET_HOLD = PIN_RESET_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   // Command port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_page,
   input wire logic [7:0] reg_cmd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rd_valid,
   output logic reg_unsupported,
   // Settings held in other pages
   input wire logic debug_config_second,
   input wire logic input_protect_signal_sel,
   input wire logic [2:0] avs_gain_scale,
   // Pins and analog comparators
   input wire logic [3:0] addr_pin,
   input wire logic data_pin_in,
   input wire logic iin_over_warn,
   input wire logic pin_over_fault,
   input wire logic pwm_self_fault_r1,
   input wire logic pwm_self_fault_r2,
   // Processor legacy-mode command
   input wire logic hc_cmd_valid,
   input wire logic hc_cmd_enable,
   // Voltage targets
   input wire logic [8:0] rail1_vid,
   input wire logic [8:0] rail2_vid_req,
   input wire logic [9:0] ovp_thr_prog,
   input wire logic [9:0] uvp_thr_prog,
   input wire logic [9:0] rvp_thr_prog,
   // Monitor path
   input wire logic mon_sample_valid,
   input wire logic [11:0] mon_adc_sample,
   output logic [12:0] monitor_final,
   output logic monitor_valid,
   // Decoded configuration
   output logic [3:0] droop_comp_resistor_qk,
   output logic droop_injection_type,
   output logic [1:0] ac_droop_bandwidth,
   output logic ac_droop_active,
   output logic input_current_report_source,
   output logic [6:0] bus_address,
   output logic spec_generation_sel,
   output logic legacy_hc_active,
   output logic input_power_alert_n,
   output logic sys_power_critical_n,
   output logic system_power_mode,
   output logic sys_voltage_fault_en,
   output logic sys_voltage_pin_mode,
   output logic sys_current_temp_pin_sel,
   output logic [20:0] report_gain_scaled,
   output logic [6:0] monitor_resistor_hk,
   output logic monitor_resistor_connected,
   output logic [3:0] monitor_mirror_gain_num,
   output logic boot_reset,
   output logic [8:0] rail2_vid_target,
   output logic vid_step_size,
   output logic [2:0] rail2_phase_count,
   output logic rail2_enabled,
   output logic cs_sum_level,
   output logic [9:0] ovp_thr_eff,
   output logic [9:0] uvp_thr_eff,
   output logic [9:0] rvp_thr_eff,
   output logic remote_amp_gain,
   output logic [8:0] current_report_offset,
   output logic [4:0] offset_resolution_5ma,
   output logic input_over_limit_flag
);
   import rcfr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Droop resistor in quarter-kilohm units
   function automatic logic [3:0] droop_res_qk(input logic [2:0] code);
      droop_res_qk = (code == 3'h0) ? 4'h1 : {code, 1'b0};
   endfunction

   // Masked register update
   function automatic logic [15:0] masked(input logic [15:0] old_val,
                                          input logic [15:0] new_val,
                                          input logic [15:0] mask);
      masked = (old_val & ~mask) | (new_val & mask);
   endfunction

   // Halved threshold
   function automatic logic [9:0] thr_eff(input logic [9:0] thr,
                                          input logic half);
      thr_eff = half ? {1'b0, thr[9:1]} : thr;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers and synchronisers

   logic [15:0] droop_control_third;
   logic [15:0] bus_address_and_input_telemetry;
   logic [15:0] current_report_gain_bus;
   logic [15:0] monitor_gain_and_resistor;
   logic [15:0] rail_multi_configuration;
   logic [15:0] rail_config_report_offset;
   logic [3:0] addr_sync_a;
   logic [3:0] addr_pin_sync;
   logic [3:0] flt_sync_a;
   logic [3:0] flt_sync;
   logic pin_fault_latched;
   logic hc_active_state;

   ////////////////////////////////////////////////////////////////////////
   // Command decode

   wire page_hit = (reg_page == REG_PAGE);
   wire wr_page = reg_wr && page_hit;
   wire wr_droop = wr_page && (reg_cmd == OFS_DROOP_CTRL3);
   wire wr_addr = wr_page && (reg_cmd == OFS_ADDR_TELEM);
   wire wr_gain = wr_page && (reg_cmd == OFS_REPORT_GAIN);
   wire wr_mon = wr_page && (reg_cmd == OFS_MON_GAIN);
   wire wr_multi = wr_page && (reg_cmd == OFS_MULTI_CFG);
   wire wr_cfg = wr_page && (reg_cmd == OFS_CFG_OFFSET);
   wire clear_faults = reg_wr && (reg_cmd == CMD_CLEAR_FAULTS);
   wire wr_known = wr_droop || wr_addr || wr_gain || wr_mon || wr_multi
                   || wr_cfg || clear_faults;

   // Synchronised comparator and fault inputs
   wire iin_over_s = flt_sync[0];
   wire pin_over_s = flt_sync[1];
   wire self_r1_s = flt_sync[2];
   wire self_r2_s = flt_sync[3];

   ////////////////////////////////////////////////////////////////////////
   // Register writes

   // Droop and address registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         droop_control_third <= RST_DROOP_CTRL3;
         bus_address_and_input_telemetry <= RST_ADDR_TELEM;
      end else begin
         if (wr_droop) begin
            droop_control_third <= masked(droop_control_third, reg_wdata,
                                          WMASK_DROOP_CTRL3);
         end
         if (wr_addr) begin
            bus_address_and_input_telemetry <= masked(
               bus_address_and_input_telemetry, reg_wdata, WMASK_ADDR_TELEM);
         end
      end
   end

   // Gain registers; reserved bits never stored
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         current_report_gain_bus <= RST_REPORT_GAIN;
         monitor_gain_and_resistor <= RST_MON_GAIN;
      end else begin
         if (wr_gain) begin
            current_report_gain_bus <= masked(current_report_gain_bus,
                                              reg_wdata,
                                              WMASK_REPORT_GAIN); // [R10]
         end
         if (wr_mon) begin
            monitor_gain_and_resistor <= masked(monitor_gain_and_resistor,
                                                reg_wdata, WMASK_MON_GAIN);
         end
      end
   end

   // Rail configuration registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rail_multi_configuration <= RST_MULTI_CFG;
         rail_config_report_offset <= RST_CFG_OFFSET;
      end else begin
         if (wr_multi) begin
            rail_multi_configuration <= masked(rail_multi_configuration,
                                               reg_wdata,
                                               WMASK_MULTI_CFG); // [R10]
         end
         if (wr_cfg) begin
            rail_config_report_offset <= masked(rail_config_report_offset,
                                                reg_wdata, WMASK_CFG_OFFSET);
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         addr_sync_a <= 4'h0;
         addr_pin_sync <= 4'h0;
         flt_sync_a <= 4'h0;
         flt_sync <= 4'h0;
      end else begin
         addr_sync_a <= addr_pin;
         addr_pin_sync <= addr_sync_a;
         flt_sync_a <= {pwm_self_fault_r2, pwm_self_fault_r1,
                        pin_over_fault, iin_over_warn};
         flt_sync <= flt_sync_a;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fault flag and legacy mode state

   // Power fault latch; a new event wins over a clear
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_fault_latched <= 1'b0;
      end else if (!input_protect_signal_sel && pin_over_s) begin
         pin_fault_latched <= 1'b1; // [R22]
      end else if (clear_faults) begin
         pin_fault_latched <= 1'b0; // [R22]
      end
   end

   // Legacy mode state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hc_active_state <= 1'b0;
      end else if (wr_addr) begin
         hc_active_state <= reg_wdata[BIT_HC_INIT]; // [R7]
      end else if (hc_cmd_valid) begin
         hc_active_state <= hc_cmd_enable; // [R7]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoded configuration

   // Droop control fields
   assign droop_comp_resistor_qk =
      droop_res_qk(droop_control_third[5:3]); // [R1]
   assign droop_injection_type = droop_control_third[BIT_INJ_TYPE]; // [R2]
   assign ac_droop_active = droop_injection_type; // [R2]
   assign ac_droop_bandwidth = droop_injection_type ?
                               droop_control_third[1:0] : 2'h0; // [R2]

   // Address and telemetry fields
   wire [3:0] addr_lower = debug_config_second ? addr_pin_sync
                           : bus_address_and_input_telemetry[11:8]; // [R5]
   assign bus_address = {bus_address_and_input_telemetry[14:12],
                         addr_lower}; // [R4]
   assign input_current_report_source =
      bus_address_and_input_telemetry[BIT_IIN_SRC]; // [R3]
   assign spec_generation_sel =
      bus_address_and_input_telemetry[BIT_SPEC_GEN]; // [R6]
   assign legacy_hc_active = hc_active_state &&
      bus_address_and_input_telemetry[BIT_HC_SUPPORT]; // [R7]
   assign system_power_mode =
      bus_address_and_input_telemetry[BIT_SYS_MODE]; // [R8]
   assign sys_voltage_fault_en =
      bus_address_and_input_telemetry[BIT_VOLT_FLT_EN]; // [R9]
   assign sys_voltage_pin_mode =
      bus_address_and_input_telemetry[BIT_VSYS_PIN]; // [R9]
   assign sys_current_temp_pin_sel =
      bus_address_and_input_telemetry[BIT_TEMP_PIN]; // [R9]

   // Over-limit flag and the chosen alert output
   wire alert_sel = bus_address_and_input_telemetry[BIT_ALERT_SEL];
   assign input_over_limit_flag = input_protect_signal_sel ? iin_over_s
                                  : pin_fault_latched; // [R22]
   assign input_power_alert_n = !(input_over_limit_flag
                                  && !alert_sel); // [R8]
   assign sys_power_critical_n = !(input_over_limit_flag
                                   && alert_sel); // [R8]

   // Report gain mantissa scaled by exponent
   wire [3:0] gain_shift = 4'(GAIN_EXP_BASE)
                           - {1'b0, current_report_gain_bus[13:11]};
   assign report_gain_scaled = 21'(current_report_gain_bus[10:0])
                               << gain_shift; // [R11]

   // Monitor resistor (half-k) and mirror gain
   wire [2:0] mon_res_code = monitor_gain_and_resistor[15:13];
   assign monitor_resistor_connected = mon_res_code[2]; // [R12]
   assign monitor_resistor_hk =
      (mon_res_code == 3'h4) ? 7'h05 :
      (mon_res_code == 3'h5) ? 7'h0A :
      (mon_res_code == 3'h6) ? 7'h14 :
      (mon_res_code == 3'h7) ? 7'h50 : 7'h00; // [R12]
   wire [1:0] mirror_code = monitor_gain_and_resistor[12:11];
   assign monitor_mirror_gain_num =
      (mirror_code == 2'h0) ? 4'h2 :
      (mirror_code == 2'h1) ? 4'h3 :
      (mirror_code == 2'h2) ? 4'h5 : 4'h8; // [R13]

   // Rail target, boot voltage and phase count
   wire pin_reset_en = rail_multi_configuration[BIT_PIN_RESET_EN];
   wire half_tracking_en = rail_multi_configuration[BIT_HALF_TRACK];
   wire [8:0] boot_voltage_code = rail_multi_configuration[12:4]; // [R17]
   assign vid_step_size = rail_multi_configuration[BIT_VID_STEP]; // [R17]
   assign rail2_vid_target = half_tracking_en ? {1'b0, rail1_vid[8:1]}
                             : rail2_vid_req; // [R16]
   wire [2:0] phase_code = rail_multi_configuration[2:0];
   assign rail2_phase_count = phase_code[2] && phase_code[1] ? 3'h6
                              : phase_code; // [R18]
   assign rail2_enabled = (phase_code != 3'h0); // [R18]

   // Sense, thresholds, amplifier gain, offset
   wire threshold_halving_en = rail_config_report_offset[BIT_THR_HALF];
   assign cs_sum_level = rail_config_report_offset[BIT_CS_SUM_LVL]; // [R19]
   assign ovp_thr_eff = thr_eff(ovp_thr_prog, threshold_halving_en); // [R19]
   assign uvp_thr_eff = thr_eff(uvp_thr_prog, threshold_halving_en); // [R19]
   assign rvp_thr_eff = thr_eff(rvp_thr_prog, threshold_halving_en); // [R19]
   assign remote_amp_gain =
      rail_config_report_offset[BIT_REMOTE_GAIN]; // [R20]
   assign current_report_offset = rail_config_report_offset[8:0]; // [R21]
   assign offset_resolution_5ma = (avs_gain_scale >= 3'h3) ?
      5'h10 >> (avs_gain_scale - 3'h3) : 5'h00; // [R21]

   ////////////////////////////////////////////////////////////////////////
   // Submodules

   // Data pin low-time detector
   logic pin_boot_reset;
   rcfr_pin_reset #(
      .HOLD_CYCLES(PIN_RESET_HOLD)
   ) u_pin_reset (
      .clk(clk),
      .sys_rst(sys_rst),
      .enable(pin_reset_en),
      .data_pin_in(data_pin_in),
      .boot_reset(pin_boot_reset)
   );
   assign boot_reset = pin_boot_reset; // [R15]

   // Monitor digital gain stage
   rcfr_monitor_calc u_monitor_calc (
      .clk(clk),
      .sys_rst(sys_rst),
      .sample_valid(mon_sample_valid),
      .adc_sample(mon_adc_sample),
      .digital_gain(monitor_gain_and_resistor[10:0]),
      .monitor_final(monitor_final),
      .monitor_valid(monitor_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read path

   // Live read values
   wire [15:0] addr_readback = {bus_address_and_input_telemetry[15:12],
                                addr_lower,
                                bus_address_and_input_telemetry[7:0]};
   wire [15:0] faults_readback = {self_r2_s, self_r1_s,
                                  input_over_limit_flag, 13'h0000};
   wire rd_page = reg_rd && page_hit;
   wire [15:0] next_rdata =
      (reg_cmd == OFS_DROOP_CTRL3) ? droop_control_third :
      (reg_cmd == OFS_ADDR_TELEM) ? addr_readback : // [R5]
      (reg_cmd == OFS_REPORT_GAIN) ? current_report_gain_bus :
      (reg_cmd == OFS_MON_GAIN) ? monitor_gain_and_resistor :
      (reg_cmd == OFS_MULTI_CFG) ? rail_multi_configuration :
      (reg_cmd == OFS_CFG_OFFSET) ? rail_config_report_offset :
      (reg_cmd == OFS_LAST_FAULTS1) ? faults_readback : 16'h0000;
   wire rd_known = rd_page && (reg_cmd inside {OFS_DROOP_CTRL3,
      OFS_ADDR_TELEM, OFS_REPORT_GAIN, OFS_MON_GAIN, OFS_MULTI_CFG,
      OFS_CFG_OFFSET, OFS_LAST_FAULTS1});

   // Read answer one cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
         reg_rd_valid <= 1'b0;
         reg_unsupported <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd;
         reg_unsupported <= (reg_rd && !rd_known)
                            || (reg_wr && !wr_known);
         if (reg_rd) begin
            reg_rdata <= rd_known ? next_rdata : 16'h0000;
         end
      end
   end
endmodule // rcfr_regs

// ### sim/rcfr_regs_assertions.sv
// Concurrent checks on the rail 2 register bank ports
`timescale 1ns/100ps
module rcfr_regs_assertions (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [1:0] reg_page,
   input wire logic reg_rd_valid,
   input wire logic reg_unsupported,
   input wire logic droop_injection_type,
   input wire logic [1:0] ac_droop_bandwidth,
   input wire logic rail2_enabled,
   input wire logic [2:0] rail2_phase_count,
   input wire logic monitor_resistor_connected,
   input wire logic [6:0] monitor_resistor_hk,
   input wire logic mon_sample_valid,
   input wire logic monitor_valid,
   input wire logic boot_reset
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // A lone read request
   sequence rd_req_s;
      reg_rd && !reg_wr;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   rd_answer_a: assert property (rd_req_s |=> reg_rd_valid)
      else $error("read not answered");
   rd_cause_a: assert property (reg_rd_valid |-> $past(reg_rd))
      else $error("answer without read");
   page_refuse_a: assert property (
      reg_rd && reg_page != 2'h2 |=> reg_unsupported)
      else $error("page not refused");
   bw_gate_a: assert property (
      !droop_injection_type |-> ac_droop_bandwidth == 2'h0)
      else $error("bandwidth in DC");
   phase_on_a: assert property (
      rail2_enabled == (rail2_phase_count != 3'h0))
      else $error("enable vs phases");
   res_conn_a: assert property (
      monitor_resistor_connected == (monitor_resistor_hk != 7'h00))
      else $error("resistor link");
   mon_valid_a: assert property (mon_sample_valid |=> monitor_valid)
      else $error("monitor late");
   boot_pulse_a: assert property ($rose(boot_reset) |=> $fell(boot_reset))
      else $error("boot pulse long");
endmodule // rcfr_regs_assertions

bind rcfr_regs rcfr_regs_assertions rcfr_regs_assertions_i (.*);

// ### sim/rcfr_host.sv
// Host model issuing register reads and writes
`timescale 1ns/100ps
module rcfr_host (
   input wire logic clk,
   input wire logic reg_rd_valid,
   input wire logic [15:0] reg_rdata,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [1:0] reg_page = 2'h2,
   output logic [7:0] reg_cmd = 8'h00,
   output logic [15:0] reg_wdata = 16'h0000
);
   // Single held request
   task automatic xfer(input logic w, input logic [1:0] p,
         input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
      @(posedge clk);
      #1;
      reg_page = p;
      reg_cmd = c;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      q = (reg_rd_valid === 1'b1) ? reg_rdata : 16'hXXXX;
   endtask
endmodule // rcfr_host

// ### sim/tb_top.sv
// Self-checking bench for the rail 2 register bank
`timescale 1ns/100ps
module tb_top;
   import rcfr_pkg::*;
   logic clk = 0, sys_rst = 1, debug_config_second = 0;
   logic input_protect_signal_sel = 0, data_pin_in = 1, iin_over_warn = 0;
   logic pin_over_fault = 0, pwm_self_fault_r1 = 0, pwm_self_fault_r2 = 0;
   logic hc_cmd_valid = 0, hc_cmd_enable = 0, mon_sample_valid = 0;
   logic [2:0] avs_gain_scale = 3'h3;
   logic [3:0] addr_pin = 4'h3;
   logic [8:0] rail1_vid = 9'h0A0, rail2_vid_req = 9'h050;
   logic [9:0] ovp_thr_prog = 10'h2A6, uvp_thr_prog = 10'h100;
   logic [9:0] rvp_thr_prog = 10'h020;
   logic [11:0] mon_adc_sample = 12'h064;
   wire reg_wr, reg_rd, reg_rd_valid, reg_unsupported, monitor_valid;
   wire droop_injection_type, ac_droop_active, input_current_report_source;
   wire spec_generation_sel, legacy_hc_active, input_power_alert_n;
   wire sys_power_critical_n, system_power_mode, sys_voltage_fault_en;
   wire sys_voltage_pin_mode, sys_current_temp_pin_sel, boot_reset;
   wire monitor_resistor_connected, vid_step_size, rail2_enabled;
   wire cs_sum_level, remote_amp_gain, input_over_limit_flag;
   wire [1:0] reg_page, ac_droop_bandwidth;
   wire [2:0] rail2_phase_count;
   wire [3:0] droop_comp_resistor_qk, monitor_mirror_gain_num;
   wire [4:0] offset_resolution_5ma;
   wire [6:0] bus_address, monitor_resistor_hk;
   wire [7:0] reg_cmd;
   wire [8:0] rail2_vid_target, current_report_offset;
   wire [9:0] ovp_thr_eff, uvp_thr_eff, rvp_thr_eff;
   wire [12:0] monitor_final;
   wire [15:0] reg_wdata, reg_rdata;
   wire [20:0] report_gain_scaled;
   logic [15:0] q;
   logic [15:0] wm[6] = '{16'hFFFF, 16'hFFFF, 16'h3FFF, 16'hFFFF,
      16'hDFFF, 16'hDFFF};
   int mg[4] = '{2, 3, 5, 8};
   int rh[4] = '{5, 10, 20, 80};
   int error_cnt = 0, checks = 0, hits = 0;
   rcfr_regs #(.PIN_RESET_HOLD(20)) rcfr_regs_i (.*);
   rcfr_host rcfr_host_i (.*);
   // 50 MHz clock
   initial begin
      forever #10 clk = !clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      rcfr_host_i.xfer(1'b1, 2'h2, c, d, q);
   endtask
   task automatic rd(input logic [7:0] c, input logic [1:0] p);
      rcfr_host_i.xfer(1'b0, p, c, 16'h0000, q);
   endtask
   task automatic chk(input string n, input logic [20:0] e,
      input logic [20:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      cyc(4);
      sys_rst = 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(OFS_DROOP_CTRL3 + 8'(i), 2'h2);
         chk("reset", 16'h0000, q);
         wr(OFS_DROOP_CTRL3 + 8'(i), 16'hFFFF);
         rd(OFS_DROOP_CTRL3 + 8'(i), 2'h2);
         chk("wmask", wm[i], q);
      end
      wr(OFS_LAST_FAULTS1, 16'hFFFF);
      rd(OFS_LAST_FAULTS1, 2'h2);
      chk("fault reg", 16'h0000, q);
      rd(OFS_MULTI_CFG, 2'h1);
      chk("other page", 1, reg_unsupported);
      chk("legacy on", 1, legacy_hc_active);
      hc_cmd_valid = 1'b1;
      cyc(1);
      hc_cmd_valid = 1'b0;
      chk("legacy", 0, legacy_hc_active);
      $display("test access done");
      for (int c = 0; c < 8; c++) begin
         wr(OFS_MULTI_CFG, 16'(c));
         chk("phases", (c > 5) ? 6 : c, rail2_phase_count);
         wr(OFS_DROOP_CTRL3, 16'(c << 3));
         chk("droop", (c == 0) ? 1 : c * 2, droop_comp_resistor_qk);
         wr(OFS_MON_GAIN, 16'((c << 13) | ((c % 4) << 11)));
         chk("mirror", mg[c % 4], monitor_mirror_gain_num);
         chk("mon res", (c < 4) ? 0 : rh[c % 4], monitor_resistor_hk);
      end
      $display("test decode done");
      wr(OFS_ADDR_TELEM, 16'h5A00);
      chk("address", 7'h5A, bus_address);
      debug_config_second = 1'b1;
      cyc(3);
      chk("pin addr", 7'h53, bus_address);
      rd(OFS_ADDR_TELEM, 2'h2);
      chk("addr read", 16'h5300, q);
      pin_over_fault = 1'b1;
      cyc(4);
      pin_over_fault = 1'b0;
      cyc(3);
      rd(OFS_LAST_FAULTS1, 2'h2);
      chk("latch", 16'h2000, q);
      wr(CMD_CLEAR_FAULTS, 16'h0000);
      cyc(1);
      chk("cleared", 1'b0, input_over_limit_flag);
      $display("test address and fault done");
      wr(OFS_MULTI_CFG, 16'h8000);
      data_pin_in = 1'b0;
      for (int n = 0; n < 40; n++) begin
         cyc(1);
         hits += int'(boot_reset === 1'b1);
      end
      data_pin_in = 1'b1;
      chk("boot pulses", 1, hits);
      wr(OFS_MON_GAIN, 16'h0200);
      mon_sample_valid = 1'b1;
      cyc(1);
      mon_sample_valid = 1'b0;
      chk("monitor", 13'h0032, monitor_final);
      wr(OFS_CFG_OFFSET, 16'h4000);
      chk("ovp halved", 10'h153, ovp_thr_eff);
      $display("test boot and monitor done");
      results();
   end
endmodule // tb_top
